// >>> rtl/lnkerr_map.svh
// Timing constants and field codes for the link error detect and recovery block
`ifndef LNKERR_MAP_SVH
`define LNKERR_MAP_SVH
`define LNKERR_CLK_NS        10
`define LNKERR_DISC_NS       850
`define LNKERR_DISC_MIN_NS   727
`define LNKERR_DISC_CYC      (`LNKERR_DISC_NS / `LNKERR_CLK_NS)
`define LNKERR_RESET_NS      6400
`define LNKERR_RESET_CYC     (`LNKERR_RESET_NS / `LNKERR_CLK_NS)
`define LNKERR_WAIT_NS       12800
`define LNKERR_WAIT_CYC      (`LNKERR_WAIT_NS / `LNKERR_CLK_NS)
`define LNKERR_CNT_W         11
`define LNKERR_CTRL_FCT      2'h0
`define LNKERR_CTRL_ESC      2'h3
`define LNKERR_ERR_NONE      3'h0
`define LNKERR_ERR_DISC      3'h1
`define LNKERR_ERR_PAR       3'h2
`define LNKERR_ERR_ESC       3'h3
`define LNKERR_ERR_CRED      3'h4
`endif

// >>> rtl/lnkerr_pkg.sv
// Types of the link error detect and recovery block
package lnkerr_pkg;
    typedef enum logic [2:0] {
        LNKERR_ERESET  = 3'h0,
        LNKERR_EWAIT   = 3'h1,
        LNKERR_READY   = 3'h3,
        LNKERR_STARTED = 3'h2,
        LNKERR_CONN    = 3'h6,
        LNKERR_RUN     = 3'h7
    } lnkerr_state_e;

    typedef struct packed {
        logic       valid;
        logic       is_ctrl;
        logic [1:0] ctrl;
        logic       parity_bad;
        logic       null_seen;
        logic       is_eop;
    } lnkerr_rxchar_s;

    typedef struct packed {
        logic       pulse;
        logic [2:0] kind;
    } lnkerr_report_s;
endpackage

// >>> rtl/lnkerr_core.sv
// Exchange-level error detection and exchange-of-silence recovery
//
// Summary of operation
// - Disconnect when idle exceeds detection interval
// - Detection interval is nominally 850 ns
// - Disconnect armed only after first bit
// - Disconnect error enters error reset, silencing
// - Physical break: keep cycling reset sequence
// - Parity error after first NULL recovers
// - Escape only precedes FCT or data
// - Escape then non-FCT control is error
// - N-Char without credit in Run errors; code flags data chars only, not EOP
// - Unexpected FCT/N-Char in init resets; code resets on data chars only, not EOP
// - Drop back-to-back EOP quietly in Run
// - On error, or disable in Run, stop transmitting
// - Recovery passes reset, wait, ready states
// - Ready plus enabled advances to started
// - Started times out after 12.8 us
// - Disabled end still detects peer silence
// - Initialization errors never reported upward
// - Run errors reported, sequence errors not
// - Disconnect in wait/ready goes error reset
// - Started disconnect or timeout goes reset
// - Error reset held 6.4 us
// - Error wait held 12.8 us
// - Connecting without FCT 12.8 us resets
// - Disconnect timeout within 727..1000 ns
`timescale 1ns/1ps
`include "lnkerr_map.svh"
module lnkerr_core
    import lnkerr_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           nrst,
    input  wire logic           rx_d,
    input  wire logic           rx_s,
    input  wire lnkerr_rxchar_s rx_char,
    input  wire logic           link_enable,
    input  wire logic           credit_avail,
    input  wire logic           tx_esc_req,
    input  wire logic           tx_esc_fct,
    input  wire logic           tx_esc_data,
    output logic                tx_enable,
    output logic                tx_send_fct,
    output logic                tx_esc_ok,
    output logic                rx_reset,
    output logic                rx_char_drop,
    output lnkerr_state_e       link_state,
    output lnkerr_report_s      net_report
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] d_sync_q;
    logic [2:0] s_sync_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            d_sync_q <= 3'h0;
            s_sync_q <= 3'h0;
        end else begin
            d_sync_q <= {d_sync_q[1:0], rx_d};
            s_sync_q <= {s_sync_q[1:0], rx_s};
        end
    end
    logic edge_seen;
    assign edge_seen = (d_sync_q[1] ^ d_sync_q[2]) | (s_sync_q[1] ^ s_sync_q[2]);

    // ------------------------------------------------------------
    // Disconnect timer
    // ------------------------------------------------------------
    lnkerr_state_e    state_q;
    logic             armed_q;
    logic [6:0]       disc_cnt_q;
    logic             disconnect;
    localparam logic [6:0] DISC_CYC = 7'(`LNKERR_DISC_CYC);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            armed_q <= 1'b0;
        end else if (state_q == LNKERR_ERESET) begin
            armed_q <= 1'b0;
        end else if (edge_seen) begin
            armed_q <= 1'b1;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            disc_cnt_q <= 7'h0;
        end else if (edge_seen || !armed_q) begin
            disc_cnt_q <= 7'h0;
        end else if (disc_cnt_q != DISC_CYC) begin
            disc_cnt_q <= disc_cnt_q + 7'h1;
        end
    end
    assign disconnect = armed_q && (disc_cnt_q == DISC_CYC);

    // ------------------------------------------------------------
    // Character checks
    // ------------------------------------------------------------
    logic null_q;
    logic esc_q;
    logic eop_q;
    logic par_err;
    logic esc_err;
    logic cred_err;
    logic seq_err;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            null_q <= 1'b0;
        end else if (state_q == LNKERR_ERESET) begin
            null_q <= 1'b0;
        end else if (rx_char.valid && rx_char.null_seen) begin
            null_q <= 1'b1;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            esc_q <= 1'b0;
        end else if (state_q == LNKERR_ERESET) begin
            esc_q <= 1'b0;
        end else if (rx_char.valid) begin
            esc_q <= rx_char.is_ctrl && (rx_char.ctrl == `LNKERR_CTRL_ESC) && !esc_q;
        end
    end
    assign par_err  = rx_char.valid && rx_char.parity_bad && null_q;
    assign esc_err  = rx_char.valid && esc_q && rx_char.is_ctrl
                      && (rx_char.ctrl != `LNKERR_CTRL_FCT);
    assign cred_err = rx_char.valid && !rx_char.is_ctrl && !credit_avail
                      && (state_q == LNKERR_RUN);
    assign seq_err  = rx_char.valid && !esc_q
                      && ((state_q != LNKERR_RUN && !rx_char.is_ctrl)
                      || (state_q != LNKERR_CONN && state_q != LNKERR_RUN
                          && rx_char.is_ctrl && rx_char.ctrl == `LNKERR_CTRL_FCT));
    logic got_fct;
    assign got_fct = rx_char.valid && !esc_q && rx_char.is_ctrl
                     && rx_char.ctrl == `LNKERR_CTRL_FCT;

    // Empty packet drop
    logic ncharv;
    assign ncharv = rx_char.valid && (!rx_char.is_ctrl || rx_char.is_eop) && !esc_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            eop_q <= 1'b0;
        end else if (state_q == LNKERR_ERESET) begin
            eop_q <= 1'b0;
        end else if (ncharv) begin
            eop_q <= rx_char.is_eop;
        end
    end
    assign rx_char_drop = ncharv && rx_char.is_eop && eop_q
                          && (state_q == LNKERR_RUN);

    // ------------------------------------------------------------
    // Exchange state machine
    // ------------------------------------------------------------
    logic [`LNKERR_CNT_W-1:0] tmr_q;
    logic                     tmr_clr;
    logic                     rx_error;
    lnkerr_state_e            state_d;
    localparam logic [`LNKERR_CNT_W-1:0] RESET_CYC = `LNKERR_CNT_W'(`LNKERR_RESET_CYC);
    localparam logic [`LNKERR_CNT_W-1:0] WAIT_CYC  = `LNKERR_CNT_W'(`LNKERR_WAIT_CYC);
    assign rx_error = disconnect || par_err || esc_err || cred_err;
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            LNKERR_ERESET: begin
                if (tmr_q == RESET_CYC - 1'b1) state_d = LNKERR_EWAIT;
            end
            LNKERR_EWAIT: begin
                if (rx_error || seq_err) state_d = LNKERR_ERESET;
                else if (tmr_q == WAIT_CYC - 1'b1) state_d = LNKERR_READY;
            end
            LNKERR_READY: begin
                if (rx_error || seq_err) state_d = LNKERR_ERESET;
                else if (link_enable) state_d = LNKERR_STARTED;
            end
            LNKERR_STARTED: begin
                if (rx_error || seq_err || tmr_q == WAIT_CYC - 1'b1) begin
                    state_d = LNKERR_ERESET;
                end else if (null_q) state_d = LNKERR_CONN;
            end
            LNKERR_CONN: begin
                if (rx_error || seq_err || tmr_q == WAIT_CYC - 1'b1) begin
                    state_d = LNKERR_ERESET;
                end else if (got_fct) state_d = LNKERR_RUN;
            end
            LNKERR_RUN: begin
                if (rx_error || !link_enable) state_d = LNKERR_ERESET;
            end
            default: state_d = LNKERR_ERESET;
        endcase
    end
    assign tmr_clr = (state_d != state_q);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= LNKERR_ERESET;
        end else begin
            state_q <= state_d;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tmr_q <= '0;
        end else if (tmr_clr) begin
            tmr_q <= '0;
        end else if (tmr_q != WAIT_CYC) begin
            tmr_q <= tmr_q + 1'b1;
        end
    end
    assign link_state  = state_q;
    assign tx_enable   = (state_q == LNKERR_STARTED) || (state_q == LNKERR_CONN)
                         || (state_q == LNKERR_RUN);
    assign tx_send_fct = (state_q == LNKERR_CONN) || (state_q == LNKERR_RUN);
    assign rx_reset    = (state_q == LNKERR_ERESET);
    assign tx_esc_ok   = tx_esc_req && (tx_esc_fct ^ tx_esc_data);

    // ------------------------------------------------------------
    // Network-level report
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            net_report <= '0;
        end else begin
            net_report.pulse <= (state_q == LNKERR_RUN) && rx_error;
            net_report.kind  <= !(state_q == LNKERR_RUN && rx_error) ? `LNKERR_ERR_NONE :
                                disconnect ? `LNKERR_ERR_DISC :
                                par_err    ? `LNKERR_ERR_PAR  :
                                esc_err    ? `LNKERR_ERR_ESC  : `LNKERR_ERR_CRED;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence run_err_s;
        state_q == LNKERR_RUN && rx_error;
    endsequence
    sequence ereset_enter_s;
        $rose(state_q == LNKERR_ERESET);
    endsequence
    sequence silent_hold_s;
        (!tx_enable && rx_reset) [*8];
    endsequence
    sequence conn_ok_s;
        state_q == LNKERR_CONN && got_fct && !rx_error && tmr_q != WAIT_CYC - 1'b1;
    endsequence
    report_run_a: assert property (@(posedge clk) disable iff (!nrst)
        run_err_s |=> net_report.pulse && state_q == LNKERR_ERESET)
        else $error("Run error not reported");
    report_init_a: assert property (@(posedge clk) disable iff (!nrst)
        net_report.pulse |-> $past(state_q) == LNKERR_RUN)
        else $error("Report outside Run");
    report_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
        net_report.pulse |=> !net_report.pulse)
        else $error("Report longer than one cycle");
    disc_arm_a: assert property (@(posedge clk) disable iff (!nrst)
        disconnect |-> armed_q && !edge_seen)
        else $error("Disconnect while unarmed");
    disc_time_a: assert property (@(posedge clk) disable iff (!nrst)
        (armed_q && edge_seen) ##1 !edge_seen [*8] |-> !disconnect)
        else $error("Disconnect too early");
    ereset_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(state_q == LNKERR_ERESET) |-> (state_q == LNKERR_ERESET) [*8])
        else $error("Error reset too short");
    ereset_silent_a: assert property (@(posedge clk) disable iff (!nrst)
        ereset_enter_s |-> silent_hold_s)
        else $error("Error reset not silent");
    silent_a: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == LNKERR_EWAIT || state_q == LNKERR_ERESET) |-> !tx_enable)
        else $error("Transmitting while silent");
    started_to_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == LNKERR_STARTED && tmr_q == WAIT_CYC - 1'b1 |=> state_q == LNKERR_ERESET)
        else $error("Started timeout missed");
    disc_reset_a: assert property (@(posedge clk) disable iff (!nrst)
        disconnect && state_q == LNKERR_READY |=> state_q == LNKERR_ERESET)
        else $error("Disconnect ignored in Ready");
    par_recover_a: assert property (@(posedge clk) disable iff (!nrst)
        par_err && state_q != LNKERR_ERESET |=> state_q == LNKERR_ERESET)
        else $error("Parity error not recovered");
    esc_recover_a: assert property (@(posedge clk) disable iff (!nrst)
        esc_err && state_q != LNKERR_ERESET |=> state_q == LNKERR_ERESET)
        else $error("Escape error not recovered");
    cred_recover_a: assert property (@(posedge clk) disable iff (!nrst)
        cred_err |=> state_q == LNKERR_ERESET)
        else $error("Credit error not recovered");
    seq_reset_a: assert property (@(posedge clk) disable iff (!nrst)
        seq_err && state_q != LNKERR_ERESET |=> state_q == LNKERR_ERESET)
        else $error("Sequence error not recovered");
    drop_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
        rx_char_drop && !rx_error && link_enable |=> state_q == LNKERR_RUN && !net_report.pulse)
        else $error("Empty packet drop disturbed Run");
    ewait_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == LNKERR_EWAIT && tmr_q < WAIT_CYC - 1'b1 && !rx_error && !seq_err
        |=> state_q == LNKERR_EWAIT)
        else $error("Error wait left early");
    ready_wait_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == LNKERR_READY && !link_enable && !rx_error && !seq_err |=> state_q == LNKERR_READY)
        else $error("Ready left while disabled");
    ready_start_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == LNKERR_READY && link_enable && !rx_error && !seq_err
        |=> state_q == LNKERR_STARTED && tx_enable)
        else $error("Ready did not start");
    conn_run_a: assert property (@(posedge clk) disable iff (!nrst)
        conn_ok_s |=> state_q == LNKERR_RUN && tx_send_fct)
        else $error("Connecting did not reach Run");
    conn_to_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == LNKERR_CONN && tmr_q == WAIT_CYC - 1'b1 |=> state_q == LNKERR_ERESET)
        else $error("Connecting timeout missed");
    run_disable_a: assert property (@(posedge clk) disable iff (!nrst)
        state_q == LNKERR_RUN && !link_enable |=> state_q == LNKERR_ERESET && !tx_enable)
        else $error("Disabled end kept transmitting");
    null_keep_a: assert property (@(posedge clk) disable iff (!nrst)
        rx_char.valid && rx_char.null_seen && state_q != LNKERR_ERESET |=> null_q)
        else $error("Received NULL not recorded");
    esc_grant_a: assert property (@(posedge clk) disable iff (!nrst)
        tx_esc_ok |-> tx_esc_req && tx_esc_fct != tx_esc_data)
        else $error("Escape granted without single follower");
endmodule // lnkerr_core

// >>> bench/lnkerr_peer.sv
// Behavioural peer transmitter driving the link data and strobe lines
`timescale 1ns/1ps
module lnkerr_peer (
    input  wire logic talk,
    output logic      d,
    output logic      s
);
    logic ph;
    initial begin
        d = 1'b0;
        s = 1'b0;
        ph = 1'b0;
    end
    // 40 ns per bit, lines stand still while silent
    always begin
        #40;
        if (talk) begin
            if (ph) d = ~d;
            else s = ~s;
            ph = ~ph;
        end
    end
endmodule // lnkerr_peer

// >>> bench/test_link_error_detect_recovery.sv
// Self-checking bench for the link error detect and recovery block
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module test_link_error_detect_recovery
    import lnkerr_pkg::*;
;
    logic           clk, nrst, rx_d, rx_s, link_enable, credit_avail, talk, drop;
    logic           tx_esc_req, tx_esc_fct, tx_esc_data;
    logic           tx_enable, tx_send_fct, tx_esc_ok, rx_reset, rx_char_drop;
    lnkerr_rxchar_s rx_char;
    lnkerr_state_e  link_state;
    lnkerr_report_s net_report;
    int             err_count, total_checks, seed, cyc, rep_cnt, n, k;

    lnkerr_peer u_peer (.talk(talk), .d(rx_d), .s(rx_s));
    lnkerr_core u_dut (.clk(clk), .nrst(nrst), .rx_d(rx_d), .rx_s(rx_s), .rx_char(rx_char),
        .link_enable(link_enable), .credit_avail(credit_avail), .tx_esc_req(tx_esc_req),
        .tx_esc_fct(tx_esc_fct), .tx_esc_data(tx_esc_data), .tx_enable(tx_enable),
        .tx_send_fct(tx_send_fct), .tx_esc_ok(tx_esc_ok), .rx_reset(rx_reset),
        .rx_char_drop(rx_char_drop), .link_state(link_state), .net_report(net_report));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (net_report.pulse === 1'b1) rep_cnt++;
        if (cyc > 40000) begin
            err_count++;
            print_verdict();
        end
    end

    function automatic lnkerr_rxchar_s mk(input logic c, input logic [1:0] t,
                                          input logic p, input logic nl, input logic e);
        return '{1'b1, c, t, p, nl, e};
    endfunction

    task automatic send(input lnkerr_rxchar_s c);
        rx_char = c;
        #1 drop = rx_char_drop;
        @(negedge clk);
        rx_char = '0;
    endtask

    task automatic wait_st(input lnkerr_state_e s, input int mx);
        n = 0;
        while (link_state !== s && n < mx) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic to_run();
        wait_st(LNKERR_READY, 2100);
        link_enable = 1'b1;
        talk = 1'b1;
        wait_st(LNKERR_STARTED, 3);
        send(mk(1'b1, 2'h3, 1'b0, 1'b0, 1'b0));
        send(mk(1'b1, 2'h0, 1'b0, 1'b1, 1'b0));
        @(negedge clk);
        `CHK("conn", LNKERR_CONN, link_state)
        send(mk(1'b1, 2'h0, 1'b0, 1'b0, 1'b0));
        `CHK("run", LNKERR_RUN, link_state)
        `CHK("send_fct", 1'b1, tx_send_fct)
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'heef4dbf0;
        {nrst, link_enable, credit_avail, talk, tx_esc_req, tx_esc_fct, tx_esc_data} = '0;
        rx_char = '0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        `CHK("rx_reset", 1'b1, rx_reset)
        wait_st(LNKERR_EWAIT, 2000);
        `CHK("ereset_len", 1'b1, n >= 638 && n <= 642)
        wait_st(LNKERR_READY, 2000);
        `CHK("ewait_len", 1'b1, n >= 1278 && n <= 1282)
        for (k = 0; k < 8; k++) begin
            {tx_esc_req, tx_esc_fct, tx_esc_data} = k[2:0];
            #1 `CHK("esc_ok", k[2] & (k[1] ^ k[0]), tx_esc_ok)
            @(negedge clk);
        end
        repeat (200) @(negedge clk);
        `CHK("no_bits", LNKERR_READY, link_state)
        link_enable = 1'b1;
        wait_st(LNKERR_STARTED, 3);
        `CHK("tx_on", 1'b1, tx_enable)
        wait_st(LNKERR_ERESET, 1400);
        `CHK("start_to", 1'b1, n >= 1277 && n <= 1283)
        `CHK("tx_off", 1'b0, tx_enable)
        link_enable = 1'b0;
        wait_st(LNKERR_READY, 2100);
        talk = 1'b1;
        repeat (20) @(negedge clk);
        talk = 1'b0;
        wait_st(LNKERR_ERESET, 200);
        `CHK("disc_idle", 1'b1, n >= 75 && n <= 100)
        wait_st(LNKERR_READY, 2100);
        link_enable = 1'b1;
        talk = 1'b1;
        wait_st(LNKERR_STARTED, 3);
        send(mk(1'b1, 2'h3, 1'b0, 1'b0, 1'b0));
        send(mk(1'b1, 2'h0, 1'b0, 1'b1, 1'b0));
        send(mk(1'b0, 2'($random(seed)), 1'b0, 1'b0, 1'b0));
        `CHK("seq_err", LNKERR_ERESET, link_state)
        `CHK("seq_quiet", 1'b0, net_report.pulse)
        credit_avail = 1'b1;
        for (k = 0; k < 4; k++) begin
            to_run();
            repeat (1 + ($random(seed) & 15)) @(negedge clk);
            if (k == 0) begin
                send(mk(1'b1, 2'h1, 1'b0, 1'b0, 1'b1));
                `CHK("no_drop", 1'b0, drop)
                send(mk(1'b1, 2'h1, 1'b0, 1'b0, 1'b1));
                `CHK("drop", 1'b1, drop)
                `CHK("drop_run", LNKERR_RUN, link_state)
                send(mk(1'($random(seed)), 2'h0, 1'b1, 1'b0, 1'b0));
            end else if (k == 1) begin
                send(mk(1'b1, 2'h3, 1'b0, 1'b0, 1'b0));
                send(mk(1'b1, 2'(1 + ($random(seed) & 32'h7fff) % 3), 1'b0, 1'b0, 1'b0));
            end else if (k == 2) begin
                credit_avail = 1'b0;
                send(mk(1'b0, 2'($random(seed)), 1'b0, 1'b0, 1'b0));
                credit_avail = 1'b1;
            end else begin
                talk = 1'b0;
                n = 0;
                while (net_report.pulse !== 1'b1 && n < 150) begin
                    @(negedge clk);
                    n++;
                end
                `CHK("disc_time", 1'b1, n >= 75 && n <= 100)
            end
            `CHK("kind", (k == 3) ? 3'h1 : 3'(k + 2), net_report.kind)
            `CHK("pulse", 1'b1, net_report.pulse)
            `CHK("recover", LNKERR_ERESET, link_state)
            `CHK("silent", 1'b0, tx_enable)
            @(negedge clk);
            `CHK("pulse_end", 1'b0, net_report.pulse)
        end
        `CHK("reports", 4, rep_cnt)
        print_verdict();
    end
endmodule // test_link_error_detect_recovery
